// ==== bssw_core.sv ====
`timescale 1ns/100ps
`default_nettype none

// Function
// - Skip next instruction when tested bit is zero
// - Skipped slot runs as no-operation, one cycle
// - Watchdog clear zeroes counter in one cycle
// - Also zero prescaler, set both flags high
// - Port register operands come from pin levels
module bssw_core #(
  parameter int unsigned WATCHDOG_W = bssw_pkg::WATCHDOG_W,
  parameter int unsigned PRESCALE_W = bssw_pkg::PRESCALE_W
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [bssw_pkg::INSTR_W-1:0] instr_word,
  input wire logic [bssw_pkg::DATA_W-1:0] rf_rd_data,
  input wire logic [bssw_pkg::DATA_W-1:0] port_a_pins,
  input wire logic [bssw_pkg::DATA_W-1:0] port_b_pins,
  output logic [bssw_pkg::ADDR_W-1:0] rf_rd_addr_r,
  output logic rf_wr_en_r,
  output logic [bssw_pkg::ADDR_W-1:0] rf_wr_addr_r,
  output logic [bssw_pkg::DATA_W-1:0] rf_wr_data_r,
  output logic nop_slot_r,
  output logic [WATCHDOG_W-1:0] watchdog_counter_r,
  output logic [PRESCALE_W-1:0] prescale_r,
  output logic timeout_flag_n_r,
  output logic powerdown_flag_n_r
);
  localparam int unsigned DW = bssw_pkg::DATA_W;

  if (WATCHDOG_W < 1 || PRESCALE_W < 1)
  begin : g_bad_width
    $error("Watchdog widths must be at least one bit");
  end

  function automatic logic is_port(input logic [bssw_pkg::ADDR_W-1:0] a);
    is_port = (a == bssw_pkg::PORT_A_ADDR) || (a == bssw_pkg::PORT_B_ADDR);
  endfunction

  // Pin synchronisers
  logic [DW-1:0] pa_meta_r, pa_sync_r, pb_meta_r, pb_sync_r;
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      pa_meta_r <= '0;
      pa_sync_r <= '0;
      pb_meta_r <= '0;
      pb_sync_r <= '0;
    end
    else
    begin
      pa_meta_r <= port_a_pins;
      pa_sync_r <= pa_meta_r;
      pb_meta_r <= port_b_pins;
      pb_sync_r <= pb_meta_r;
    end
  end

  // Execute stage
  logic ex_valid_r, ex_valid_nxt;
  logic [bssw_pkg::INSTR_W-1:0] ex_word_r, ex_word_nxt;
  logic [bssw_pkg::ADDR_W-1:0] rf_rd_addr_nxt;
  logic set_op, skip_op, wclr_op;
  logic [bssw_pkg::BIT_SEL_W-1:0] bsel;
  logic [bssw_pkg::ADDR_W-1:0] faddr;
  logic [bssw_pkg::ADDR_W-1:0] fetch_addr;
  logic [DW-1:0] operand, bit_mask;
  logic do_set, do_skip, do_wclr;
  logic rf_wr_en_nxt, nop_slot_nxt;
  logic [bssw_pkg::ADDR_W-1:0] rf_wr_addr_nxt;
  logic [DW-1:0] rf_wr_data_nxt;

  bssw_decode u_dec_ex (
    .instr_word(ex_word_r),
    .set_bit_op(set_op),
    .skip_if_bit_clear_op(skip_op),
    .watchdog_clear_op(wclr_op),
    .bit_sel(bsel),
    .file_addr(faddr)
  );

  bssw_decode u_dec_fetch (
    .instr_word(instr_word),
    .set_bit_op(),
    .skip_if_bit_clear_op(),
    .watchdog_clear_op(),
    .bit_sel(),
    .file_addr(fetch_addr)
  );

  always_comb
  begin
    bit_mask = DW'(1) << bsel;
    operand = rf_rd_data;
    if (faddr == bssw_pkg::PORT_A_ADDR)
      operand = pa_sync_r;
    else if (faddr == bssw_pkg::PORT_B_ADDR)
      operand = pb_sync_r;
    do_set = ex_valid_r && set_op;
    do_skip = ex_valid_r && skip_op && !operand[bsel];
    do_wclr = ex_valid_r && wclr_op;
    // Prefetched word is discarded when the skip fires
    ex_valid_nxt = instr_valid && !do_skip;
    nop_slot_nxt = do_skip;
    ex_word_nxt = instr_valid ? instr_word : ex_word_r;
    rf_rd_addr_nxt = instr_valid ? fetch_addr : rf_rd_addr_r;
    rf_wr_en_nxt = do_set;
    rf_wr_addr_nxt = do_set ? faddr : rf_wr_addr_r;
    rf_wr_data_nxt = do_set ? (operand | bit_mask) : rf_wr_data_r;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      ex_valid_r <= 1'b0;
      ex_word_r <= '0;
      rf_rd_addr_r <= '0;
      rf_wr_en_r <= 1'b0;
      rf_wr_addr_r <= '0;
      rf_wr_data_r <= '0;
      nop_slot_r <= 1'b0;
    end
    else
    begin
      ex_valid_r <= ex_valid_nxt;
      ex_word_r <= ex_word_nxt;
      rf_rd_addr_r <= rf_rd_addr_nxt;
      rf_wr_en_r <= rf_wr_en_nxt;
      rf_wr_addr_r <= rf_wr_addr_nxt;
      rf_wr_data_r <= rf_wr_data_nxt;
      nop_slot_r <= nop_slot_nxt;
    end
  end

  // Watchdog with prescaler
  logic [WATCHDOG_W-1:0] wdog_nxt;
  logic [PRESCALE_W-1:0] pre_nxt;
  logic tmo_n_nxt, pwrdn_n_nxt;
  logic wdog_wrap;
  always_comb
  begin
    wdog_wrap = (&prescale_r) && (&watchdog_counter_r);
    pre_nxt = prescale_r + PRESCALE_W'(1);
    wdog_nxt = watchdog_counter_r;
    tmo_n_nxt = timeout_flag_n_r;
    pwrdn_n_nxt = powerdown_flag_n_r;
    if (&prescale_r)
    begin
      wdog_nxt = watchdog_counter_r + WATCHDOG_W'(1);
      if (wdog_wrap)
        tmo_n_nxt = 1'b0;
    end
    if (do_wclr)
    begin
      wdog_nxt = '0;
      pre_nxt = '0;
      tmo_n_nxt = 1'b1;
      pwrdn_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      watchdog_counter_r <= '0;
      prescale_r <= '0;
      timeout_flag_n_r <= bssw_pkg::FLAG_N_RESET;
      powerdown_flag_n_r <= bssw_pkg::FLAG_N_RESET;
    end
    else
    begin
      watchdog_counter_r <= wdog_nxt;
      prescale_r <= pre_nxt;
      timeout_flag_n_r <= tmo_n_nxt;
      powerdown_flag_n_r <= pwrdn_n_nxt;
    end
  end

  skip_taken_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ex_valid_r && skip_op && !operand[bsel] |=> nop_slot_r && !ex_valid_r ##1 !nop_slot_r)
    else $error("skip not taken on clear bit");
  skip_not_taken_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ex_valid_r && skip_op && operand[bsel] && instr_valid |=> !nop_slot_r && ex_valid_r)
    else $error("skip taken on set bit");
  nop_pairing_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    nop_slot_r |-> $past(ex_valid_r) && !ex_valid_r)
    else $error("nop slot without a skipping test");
  wdog_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ex_valid_r && wclr_op |=> watchdog_counter_r == '0)
    else $error("watchdog not cleared");
  wdog_flags_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ex_valid_r && wclr_op |=> prescale_r == '0 && timeout_flag_n_r && powerdown_flag_n_r)
    else $error("prescaler or flags wrong after watchdog clear");
  set_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ex_valid_r && set_op |=> rf_wr_en_r && rf_wr_data_r == ($past(operand) | $past(bit_mask))
      && rf_wr_addr_r == $past(faddr) && ($stable(timeout_flag_n_r) || $past(wdog_wrap))
      ##1 !rf_wr_en_r || $past(do_set))
    else $error("bit set write wrong");
  port_pins_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ex_valid_r && set_op && faddr == bssw_pkg::PORT_A_ADDR |=> rf_wr_data_r == ($past(pa_sync_r) | $past(bit_mask)))
    else $error("port operand not taken from pins");
  nop_cause_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    nop_slot_r |-> $past(ex_valid_r) && $past(skip_op))
    else $error("nop slot not caused by a test instruction");
  wdog_one_cycle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ex_valid_r && wclr_op && instr_valid |=> ex_valid_r && !nop_slot_r)
    else $error("watchdog clear took more than one cycle");
  set_one_cycle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ex_valid_r && set_op && instr_valid |=> ex_valid_r && !nop_slot_r)
    else $error("bit set took more than one cycle");

  skip_cov: cover property (@(posedge clk_sys) disable iff (!resetn) nop_slot_r);
  set_port_cov: cover property (@(posedge clk_sys) disable iff (!resetn) do_set && is_port(faddr));
  wclr_cov: cover property (@(posedge clk_sys) disable iff (!resetn) do_wclr && !timeout_flag_n_r);
  skip_pass_cov: cover property (@(posedge clk_sys) disable iff (!resetn) ex_valid_r && skip_op && operand[bsel]);
endmodule

`default_nettype wire

// ==== bssw_decode.sv ====
`timescale 1ns/100ps
`default_nettype none

package bssw_pkg;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BIT_SEL_W = 3;
  localparam int unsigned CLASS_MSB = 13;
  localparam int unsigned CLASS_LSB = 10;
  localparam int unsigned BIT_SEL_MSB = 9;
  localparam int unsigned BIT_SEL_LSB = 7;
  localparam int unsigned ADDR_MSB = 6;
  localparam logic [3:0] SET_BIT_CLASS = 4'h5;
  localparam logic [3:0] SKIP_CLEAR_CLASS = 4'h6;
  localparam logic [INSTR_W-1:0] WATCHDOG_CLEAR_WORD = 14'h0064;
  localparam logic [ADDR_W-1:0] PORT_A_ADDR = 7'h05;
  localparam logic [ADDR_W-1:0] PORT_B_ADDR = 7'h06;
  localparam logic FLAG_N_RESET = 1'h1;
  localparam int unsigned WATCHDOG_W = 8;
  localparam int unsigned PRESCALE_W = 7;
endpackage

module bssw_decode (
  input wire logic [bssw_pkg::INSTR_W-1:0] instr_word,
  output logic set_bit_op,
  output logic skip_if_bit_clear_op,
  output logic watchdog_clear_op,
  output logic [bssw_pkg::BIT_SEL_W-1:0] bit_sel,
  output logic [bssw_pkg::ADDR_W-1:0] file_addr
);
  always_comb
  begin
    set_bit_op = instr_word[bssw_pkg::CLASS_MSB:bssw_pkg::CLASS_LSB] == bssw_pkg::SET_BIT_CLASS;
    skip_if_bit_clear_op = instr_word[bssw_pkg::CLASS_MSB:bssw_pkg::CLASS_LSB] == bssw_pkg::SKIP_CLEAR_CLASS;
    watchdog_clear_op = instr_word == bssw_pkg::WATCHDOG_CLEAR_WORD;
    bit_sel = instr_word[bssw_pkg::BIT_SEL_MSB:bssw_pkg::BIT_SEL_LSB];
    file_addr = instr_word[bssw_pkg::ADDR_MSB:0];
  end
endmodule

`default_nettype wire

// ==== bssw_rf_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module bssw_rf_model (
  input wire logic clk_sys,
  input wire logic [bssw_pkg::ADDR_W-1:0] rd_addr,
  output logic [bssw_pkg::DATA_W-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [bssw_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [bssw_pkg::DATA_W-1:0] wr_data
);
  logic [bssw_pkg::DATA_W-1:0] mem [0:127];
  // Each cell starts as its address mixed with a pattern
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 8'(i) ^ 8'h5A;
  end
  assign rd_data = mem[rd_addr];
  always @(posedge clk_sys)
    if (wr_en)
      mem[wr_addr] <= wr_data;
endmodule
`default_nettype wire

// ==== bit_skip_set_wdt_clear_exec_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module bit_skip_set_wdt_clear_exec_test;
  logic clk_sys;
  logic resetn;
  logic instr_valid;
  logic [bssw_pkg::INSTR_W-1:0] instr_word;
  logic [7:0] rf_rd_data;
  logic [7:0] pa;
  logic [7:0] pb;
  logic [6:0] rd_addr;
  logic wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic nop_slot;
  logic [7:0] wdog;
  logic [6:0] presc;
  logic tmo_n;
  logic pwrdn_n;
  int miscompares;
  int checks_done;
  bssw_core bssw_core_inst (.clk_sys(clk_sys), .resetn(resetn), .instr_valid(instr_valid),
    .instr_word(instr_word), .rf_rd_data(rf_rd_data), .port_a_pins(pa), .port_b_pins(pb),
    .rf_rd_addr_r(rd_addr), .rf_wr_en_r(wr_en), .rf_wr_addr_r(wr_addr), .rf_wr_data_r(wr_data),
    .nop_slot_r(nop_slot), .watchdog_counter_r(wdog), .prescale_r(presc),
    .timeout_flag_n_r(tmo_n), .powerdown_flag_n_r(pwrdn_n));
  bssw_rf_model bssw_rf_model_inst (.clk_sys(clk_sys), .rd_addr(rd_addr), .rd_data(rf_rd_data),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [13:0] enc(input logic [3:0] c, input logic [2:0] b, input logic [6:0] a);
    return {c, b, a};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [13:0] w);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w;
  endtask
  task automatic stop();
    @(posedge clk_sys);
    instr_valid <= 1'b0;
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic test_set();
    send(enc(bssw_pkg::SET_BIT_CLASS, 3'h2, 7'h20));
    send(enc(bssw_pkg::SET_BIT_CLASS, 3'h0, 7'h22));
    stop();
    edges(0);
    chk({7'h00, wr_en}, 8'h01);
    chk({1'b0, wr_addr}, 8'h20);
    chk(wr_data, 8'h7E);
    chk({6'h00, tmo_n, pwrdn_n}, 8'h03);
    edges(1);
    chk({7'h00, wr_en}, 8'h01);
    chk({1'b0, wr_addr}, 8'h22);
    chk(wr_data, 8'h79);
    edges(1);
    chk({7'h00, wr_en}, 8'h00);
  endtask
  // Test word then a set word back to back; the set runs only if not skipped
  task automatic test_skip(input logic [2:0] b, input logic [6:0] a, input logic [6:0] f, input logic sk);
    send(enc(bssw_pkg::SKIP_CLEAR_CLASS, b, a));
    send(enc(bssw_pkg::SET_BIT_CLASS, 3'h7, f));
    stop();
    edges(0);
    chk({7'h00, nop_slot}, {7'h00, sk});
    edges(1);
    chk({7'h00, wr_en}, {7'h00, ~sk});
    chk({7'h00, nop_slot}, 8'h00);
    if (!sk)
      chk(wr_data, (8'(f) ^ 8'h5A) | 8'h80);
  endtask
  task automatic test_pins();
    send(enc(bssw_pkg::SET_BIT_CLASS, 3'h0, bssw_pkg::PORT_A_ADDR));
    stop();
    edges(1);
    chk({7'h00, wr_en}, 8'h01);
    chk(wr_data, 8'h31);
  endtask
  // Clear followed back to back by a set, which must still run
  task automatic test_wdog();
    int n;
    n = 0;
    while (tmo_n !== 1'b0 && n < 40000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk({7'h00, tmo_n}, 8'h00);
    edges(200);
    send(bssw_pkg::WATCHDOG_CLEAR_WORD);
    send(enc(bssw_pkg::SET_BIT_CLASS, 3'h0, 7'h40));
    stop();
    edges(0);
    chk(wdog, 8'h00);
    chk({1'b0, presc}, 8'h00);
    chk({6'h00, tmo_n, pwrdn_n}, 8'h03);
    edges(1);
    chk({7'h00, wr_en}, 8'h01);
    chk(wr_data, 8'h1B);
  endtask
  task automatic report_and_stop();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (checks_done > 0 && miscompares == 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    miscompares = 0;
    checks_done = 0;
    resetn = 1'b0;
    instr_valid = 1'b0;
    instr_word = 14'h0000;
    pa = 8'h30;
    pb = 8'hC1;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    test_set();
    test_skip(3'h2, 7'h21, 7'h31, 1'b1);
    test_skip(3'h0, 7'h21, 7'h30, 1'b0);
    test_skip(3'h0, bssw_pkg::PORT_B_ADDR, 7'h32, 1'b0);
    test_pins();
    test_wdog();
    report_and_stop();
  end
  // Watchdog on the run itself
  initial
  begin
    #(60000 * 40);
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
